// >>> pkg/rmsc_pkg.sv
// Constants and types shared by the radio module setting block
package rmsc_pkg;

    localparam int CLK_HZ = 10_000_000;

    // Register byte offsets
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_BAUD = 8'h04;
    localparam logic [7:0] A_CCA  = 8'h08;
    localparam logic [7:0] A_ESC  = 8'h0c;
    localparam logic [7:0] A_CHAN = 8'h10;
    localparam logic [7:0] A_TMO  = 8'h14;
    localparam logic [7:0] A_IOF  = 8'h18;
    localparam logic [7:0] A_SCAN = 8'h1c;
    localparam logic [7:0] A_CTRL = 8'h20;

    // Field positions
    localparam int MODE_COORD_BIT = 2;
    localparam int CTRL_LEAVE_BIT = 0;
    localparam int CTRL_CLR_BIT   = 1;
    localparam int IOF_W          = 3;
    localparam int IO_LINES       = 5;

    // Reset values and limits
    localparam logic [1:0]  FRAMED_RST   = 2'h0;
    localparam logic [1:0]  FRAMED_MAX   = 2'h2;
    localparam logic        COORD_RST    = 1'h0;
    localparam logic [17:0] BAUD_RST     = 18'h00003;
    localparam logic [31:0] BAUD_STD_MAX = 32'h00000007;
    localparam logic [31:0] BAUD_LIT_MAX = 32'h0003d090;
    localparam logic [6:0]  CCA_RST      = 7'h2c;
    localparam logic [31:0] CCA_MAX      = 32'h00000050;
    localparam logic [7:0]  ESC_RST      = 8'h2b;
    localparam logic [4:0]  CHAN_RST     = 5'h0c;
    localparam logic [4:0]  CHAN_MIN     = 5'h0b;
    localparam logic [4:0]  CHAN_MAX     = 5'h1a;
    localparam logic [15:0] TMO_RST      = 16'h0064;
    localparam logic [31:0] TMO_MIN      = 32'h00000002;
    localparam logic [31:0] TMO_MAX      = 32'h0000ffff;
    localparam logic [2:0]  IOF_RST      = 3'h0;
    localparam logic [2:0]  IOF_ADC      = 3'h2;
    localparam logic [2:0]  IOF_DO_LOW   = 3'h4;
    localparam logic [2:0]  IOF_DO_HIGH  = 3'h5;
    localparam logic [31:0] SCAN_EXP_MAX = 32'h00000006;
    localparam logic [2:0]  REC_MAX      = 3'h5;

    // Timing
    localparam int TMO_UNIT_MS       = 100;
    localparam int TMO_UNIT_CYCLES   = TMO_UNIT_MS * (CLK_HZ / 1000);
    localparam int SCAN_UNIT_US      = 15360;
    localparam int SCAN_UNIT_CYCLES  = SCAN_UNIT_US * (CLK_HZ / 1_000_000);
    localparam int SCAN_CHANNELS     = 16;
    localparam int GUARD_MS          = 1000;
    localparam int GUARD_CYCLES      = GUARD_MS * (CLK_HZ / 1000);

    // Bit-clock divisors of the standard rates; the top entry gives 111111 baud
    localparam int STD_DIV [8] = '{8333, 4167, 2083, 1042, 521, 260, 174, 90};

    typedef enum logic [1:0] {
        SC_IDLE  = 2'b01,
        SC_DWELL = 2'b10
    } rmsc_scan_t;

endpackage : rmsc_pkg

// >>> rtl/radio_module_setting_commands.sv
// Command-mode setting registers, scan sequencer and serial rate control
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Framed mode 0 transparent, 1 framed, 2 escaped
// - Scan sends broadcast beacon request every channel
// - Dwell is two-power exponent times 15.36 ms
// - At most five beacon records per scan
// - Record fields in fixed order, address modes
// - Superframe field bit layout is fixed
// - Text mode ends fields with CR
// - Rate settings 0-7 map to standard rates
// - New rate applies only on the leave command, not on timeout
// - Larger values are literal rates, nearest stored
// - Nominal 115200 setting really runs 111111 baud
// - Radio data rate ignores host rate
// - Block transmit when channel energy is below threshold
// - Guard, escape char, guard enters command mode
// - Role 0 end device, 1 coordinator
// - Channels 0x0B to 0x1A, default 0x0C
// - Leave command immediately exits command mode
// - Inactivity timeout in 100 ms units
// - Each I/O line follows its function setting
module radio_module_setting_commands #(
    parameter int GUARD_CYC = rmsc_pkg::GUARD_CYCLES,
    parameter int TMO_CYC   = rmsc_pkg::TMO_UNIT_CYCLES,
    parameter int SCAN_CYC  = rmsc_pkg::SCAN_UNIT_CYCLES,
    parameter int SCAN_CHS  = rmsc_pkg::SCAN_CHANNELS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        serValid,
    input  wire logic [7:0]  serByte,
    input  wire logic        beaconHeard,
    input  wire logic        txRequest,
    input  wire logic [6:0]  energyLevel,
    output logic             cmdMode,
    output logic      [1:0]  framedMode,
    output logic             fieldTerminator,
    output logic             coordinatorRole,
    output logic      [4:0]  rfChannel,
    output logic      [20:0] baudDivisor,
    output logic             txGrant,
    output logic             txBlock,
    output logic             scanActive,
    output logic      [4:0]  scanChannel,
    output logic             beaconRequest,
    output logic             recordAccept,
    output logic      [2:0]  recordCount,
    output logic      [4:0]  ioOut,
    output logic      [4:0]  ioOe,
    output logic      [4:0]  adcEnable
);

    typedef struct packed {
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic                cmdMode;
        logic                err;
        logic [1:0]          framed;
        logic                crEn;
        logic                coord;
        logic [17:0]         baudSet;
        logic [20:0]         baudPend;
        logic [20:0]         baudDiv;
        logic [6:0]          cca;
        logic [7:0]          esc;
        logic [4:0]          chan;
        logic [15:0]         tmo;
        logic [14:0]         iof;
        logic [31:0]         idle;
        logic                escSeen;
        logic [31:0]         tick;
        logic [15:0]         units;
        rmsc_pkg::rmsc_scan_t scan;
        logic [2:0]          scanExp;
        logic [4:0]          scanChan;
        logic [31:0]         dwell;
        logic [2:0]          records;
        logic                beaconReq;
        logic                recAcc;
        logic                txGrant;
        logic                txBlock;
        logic [4:0]          ioOut;
        logic [4:0]          ioOe;
        logic [4:0]          adcEn;
    } rmsc_state_t;

    rmsc_state_t s_q;
    rmsc_state_t s_d;

    // Nearest divisor for a literal rate; rounding keeps the error smallest
    function automatic logic [20:0] litDiv(input logic [17:0] rate);
        litDiv = 21'((rmsc_pkg::CLK_HZ + 32'(rate) / 2) / 32'(rate));
    endfunction : litDiv

    function automatic logic [31:0] dwellLen(input logic [2:0] expo);
        dwellLen = 32'(SCAN_CYC) << expo;
    endfunction : dwellLen

    logic        apbDone;
    logic        apbWr;
    logic        leaveReq;
    logic [4:0]  lastChan;

    assign apbDone  = psel & penable & s_q.pready;
    assign apbWr    = apbDone & pwrite & ~s_q.pslverr;
    assign leaveReq = apbWr & (paddr == rmsc_pkg::A_CTRL) & pwdata[rmsc_pkg::CTRL_LEAVE_BIT];
    assign lastChan = 5'(rmsc_pkg::CHAN_MIN + 5'(SCAN_CHS - 1));

    always_comb
    begin
        logic [31:0] rd;
        logic        rangeBad;
        logic        unmapped;
        logic        scanBusy;
        logic [17:0] wv;
        rd       = 32'h00000000;
        rangeBad = 1'b0;
        unmapped = 1'b0;
        scanBusy = (s_q.scan == rmsc_pkg::SC_DWELL);
        wv       = pwdata[17:0];
        s_d           = s_q;
        s_d.beaconReq = 1'b0;
        s_d.recAcc    = 1'b0;
        s_d.txGrant   = 1'b0;
        s_d.txBlock   = 1'b0;

        case (paddr)
            rmsc_pkg::A_MODE:
            begin
                rd       = {29'h0, s_q.coord, s_q.framed};
                rangeBad = (pwdata[1:0] > rmsc_pkg::FRAMED_MAX) | (|pwdata[31:3]);
            end
            rmsc_pkg::A_BAUD:
            begin
                rd       = {14'h0, s_q.baudSet};
                rangeBad = pwdata > rmsc_pkg::BAUD_LIT_MAX;
            end
            rmsc_pkg::A_CCA:
            begin
                rd       = {25'h0, s_q.cca};
                rangeBad = pwdata > rmsc_pkg::CCA_MAX;
            end
            rmsc_pkg::A_ESC:
            begin
                rd       = {24'h0, s_q.esc};
                rangeBad = |pwdata[31:8];
            end
            rmsc_pkg::A_CHAN:
            begin
                rd       = {27'h0, s_q.chan};
                rangeBad = (pwdata < 32'(rmsc_pkg::CHAN_MIN)) | (pwdata > 32'(rmsc_pkg::CHAN_MAX));
            end
            rmsc_pkg::A_TMO:
            begin
                rd       = {16'h0, s_q.tmo};
                rangeBad = (pwdata < rmsc_pkg::TMO_MIN) | (pwdata > rmsc_pkg::TMO_MAX);
            end
            rmsc_pkg::A_IOF:
            begin
                rd       = {17'h0, s_q.iof};
                rangeBad = |pwdata[31:15];
                for (int i = 0; i < rmsc_pkg::IO_LINES; i++)
                begin
                    if (pwdata[i*rmsc_pkg::IOF_W +: rmsc_pkg::IOF_W] > rmsc_pkg::IOF_DO_HIGH)
                    begin
                        rangeBad = 1'b1;
                    end
                end
            end
            rmsc_pkg::A_SCAN:
            begin
                rd       = {19'h0, s_q.scanChan, 1'b0, s_q.records, scanBusy, s_q.scanExp};
                rangeBad = (pwdata > rmsc_pkg::SCAN_EXP_MAX) | scanBusy;
            end
            rmsc_pkg::A_CTRL:
            begin
                rd       = {30'h0, s_q.err, s_q.cmdMode};
                rangeBad = pwdata[rmsc_pkg::CTRL_LEAVE_BIT] & ~s_q.cmdMode;
            end
            default:
            begin
                unmapped = 1'b1;
            end
        endcase

        // One wait state: answer is latched in the first access cycle
        s_d.pready = psel & penable & ~s_q.pready;
        if (psel & penable & ~s_q.pready)
        begin
            s_d.prdata = rd;
            s_d.pslverr = unmapped | (pwrite & (rangeBad | (~s_q.cmdMode & (paddr != rmsc_pkg::A_CTRL))));
        end

        if (apbWr)
        begin
            case (paddr)
                rmsc_pkg::A_MODE:
                begin
                    s_d.framed = pwdata[1:0];
                    s_d.coord = pwdata[rmsc_pkg::MODE_COORD_BIT];
                end
                rmsc_pkg::A_BAUD:
                begin
                    if (pwdata <= rmsc_pkg::BAUD_STD_MAX)
                    begin
                        s_d.baudSet  = wv;
                        s_d.baudPend = 21'(rmsc_pkg::STD_DIV[wv[2:0]]);
                    end
                    else
                    begin
                        s_d.baudPend = litDiv(wv);
                        s_d.baudSet  = 18'(rmsc_pkg::CLK_HZ / 32'(litDiv(wv)));
                    end
                end
                rmsc_pkg::A_CCA:  s_d.cca = pwdata[6:0];
                rmsc_pkg::A_ESC:  s_d.esc = pwdata[7:0];
                rmsc_pkg::A_CHAN: s_d.chan = pwdata[4:0];
                rmsc_pkg::A_TMO:  s_d.tmo = pwdata[15:0];
                rmsc_pkg::A_IOF:  s_d.iof = pwdata[14:0];
                rmsc_pkg::A_SCAN:
                begin
                    // start broadcast scan on first channel
                    s_d.scan      = rmsc_pkg::SC_DWELL;
                    s_d.scanExp   = pwdata[2:0];
                    s_d.scanChan  = rmsc_pkg::CHAN_MIN;
                    s_d.dwell     = 32'h00000000;
                    s_d.records   = 3'h0;
                    s_d.beaconReq = 1'b1;
                end
                rmsc_pkg::A_CTRL:
                begin
                    if (pwdata[rmsc_pkg::CTRL_CLR_BIT])
                    begin
                        s_d.err = 1'b0;
                    end
                    if (pwdata[rmsc_pkg::CTRL_LEAVE_BIT])
                    begin
                        s_d.cmdMode = 1'b0;
                        s_d.baudDiv = s_q.baudPend;
                        s_d.escSeen = 1'b0;
                        s_d.idle    = 32'h00000000;
                    end
                end
                default:
                begin
                end
            endcase
        end

        // Rejected write flags error; set wins over a clear
        if (apbDone & pwrite & s_q.pslverr)
        begin
            s_d.err = 1'b1;
        end

        if (s_q.cmdMode & ~leaveReq)
        begin
            if (apbDone)
            begin
                s_d.tick  = 32'h00000000;
                s_d.units = 16'h0000;
            end
            else if (s_q.tick == 32'(TMO_CYC - 1))
            begin
                s_d.tick  = 32'h00000000;
                s_d.units = s_q.units + 16'h0001;
                if (s_q.units + 16'h0001 >= s_q.tmo)
                begin
                    s_d.cmdMode = 1'b0;
                    s_d.idle    = 32'h00000000;
                end
            end
            else
            begin
                s_d.tick = s_q.tick + 32'h00000001;
            end
        end
        else if (~s_q.cmdMode)
        begin
            if (serValid)
            begin
                s_d.escSeen = ~s_q.escSeen & (s_q.idle >= 32'(GUARD_CYC)) & (serByte == s_q.esc);
                s_d.idle    = 32'h00000000;
            end
            else if (s_q.idle < 32'(GUARD_CYC))
            begin
                s_d.idle = s_q.idle + 32'h00000001;
            end
            else if (s_q.escSeen)
            begin
                s_d.cmdMode = 1'b1;
                s_d.escSeen = 1'b0;
                s_d.tick    = 32'h00000000;
                s_d.units   = 16'h0000;
            end
        end

        unique case (s_q.scan)
            rmsc_pkg::SC_IDLE:
            begin
            end
            rmsc_pkg::SC_DWELL:
            begin
                // accept pulse opens one fixed-layout record
                if (beaconHeard & (s_q.records < rmsc_pkg::REC_MAX))
                begin
                    s_d.records = s_q.records + 3'h1;
                    s_d.recAcc  = 1'b1;
                end
                if (s_q.dwell == dwellLen(s_q.scanExp) - 32'h00000001)
                begin
                    s_d.dwell = 32'h00000000;
                    if (s_q.scanChan == lastChan)
                    begin
                        s_d.scan = rmsc_pkg::SC_IDLE;
                    end
                    else
                    begin
                        s_d.scanChan  = s_q.scanChan + 5'h01;
                        s_d.beaconReq = 1'b1;
                    end
                end
                else
                begin
                    s_d.dwell = s_q.dwell + 32'h00000001;
                end
            end
        endcase

        if (txRequest)
        begin
            s_d.txBlock = energyLevel < s_q.cca;
            s_d.txGrant = ~(energyLevel < s_q.cca);
        end

        s_d.crEn = (s_q.framed == rmsc_pkg::FRAMED_RST);

        for (int i = 0; i < rmsc_pkg::IO_LINES; i++)
        begin
            s_d.ioOe[i]  = s_q.iof[i*rmsc_pkg::IOF_W +: rmsc_pkg::IOF_W] >= rmsc_pkg::IOF_DO_LOW;
            s_d.ioOut[i] = s_q.iof[i*rmsc_pkg::IOF_W +: rmsc_pkg::IOF_W] == rmsc_pkg::IOF_DO_HIGH;
            s_d.adcEn[i] = s_q.iof[i*rmsc_pkg::IOF_W +: rmsc_pkg::IOF_W] == rmsc_pkg::IOF_ADC;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q          <= '0;
            s_q.framed   <= rmsc_pkg::FRAMED_RST;
            s_q.crEn     <= 1'b1;
            s_q.coord    <= rmsc_pkg::COORD_RST;
            s_q.baudSet  <= rmsc_pkg::BAUD_RST;
            s_q.baudPend <= 21'(rmsc_pkg::STD_DIV[3]);
            s_q.baudDiv  <= 21'(rmsc_pkg::STD_DIV[3]);
            s_q.cca      <= rmsc_pkg::CCA_RST;
            s_q.esc      <= rmsc_pkg::ESC_RST;
            s_q.chan     <= rmsc_pkg::CHAN_RST;
            s_q.tmo      <= rmsc_pkg::TMO_RST;
            s_q.scan     <= rmsc_pkg::SC_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // no radio rate output depends on the host rate
    assign prdata          = s_q.prdata;
    assign pready          = s_q.pready;
    assign pslverr         = s_q.pslverr;
    assign cmdMode         = s_q.cmdMode;
    assign framedMode      = s_q.framed;
    assign fieldTerminator = s_q.crEn;
    assign coordinatorRole = s_q.coord;
    assign rfChannel       = s_q.chan;
    assign baudDivisor     = s_q.baudDiv;
    assign txGrant         = s_q.txGrant;
    assign txBlock         = s_q.txBlock;
    // One-hot code: bit 1 alone marks the dwell state, so no decode is needed
    assign scanActive      = s_q.scan[1];
    assign scanChannel     = s_q.scanChan;
    assign beaconRequest   = s_q.beaconReq;
    assign recordAccept    = s_q.recAcc;
    assign recordCount     = s_q.records;
    assign ioOut           = s_q.ioOut;
    assign ioOe            = s_q.ioOe;
    assign adcEnable       = s_q.adcEn;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence chanWriteRejected;
        apbDone & pwrite & s_q.pslverr & (paddr == rmsc_pkg::A_CHAN);
    endsequence
    sequence scanStart;
        apbWr & (paddr == rmsc_pkg::A_SCAN);
    endsequence

    chk_reject_keeps_value: assert property (chanWriteRejected |=> $stable(rfChannel) & s_q.err)
        else $error("rejected channel write changed state");
    chk_cca_blocks_tx: assert property (txRequest & (energyLevel < s_q.cca) |=> txBlock & ~txGrant)
        else $error("busy channel not blocked");
    chk_cca_grants_tx: assert property (txRequest & (energyLevel >= s_q.cca) |=> txGrant & ~txBlock)
        else $error("clear channel not granted");
    chk_baud_holds: assert property (~leaveReq |=> $stable(baudDivisor))
        else $error("host rate changed without leaving command mode");
    chk_leave_exits: assert property (leaveReq |=> ~cmdMode & (baudDivisor == $past(s_q.baudPend)))
        else $error("leave did not exit command mode");
    chk_record_cap: assert property (recordCount <= rmsc_pkg::REC_MAX)
        else $error("more than five beacon records");
    chk_channel_range: assert property ((rfChannel >= rmsc_pkg::CHAN_MIN) & (rfChannel <= rmsc_pkg::CHAN_MAX))
        else $error("channel out of range");
    chk_framed_range: assert property (framedMode <= rmsc_pkg::FRAMED_MAX)
        else $error("framed mode out of range");
    chk_scan_first_chan: assert property (scanStart |=> scanActive & beaconRequest & (scanChannel == rmsc_pkg::CHAN_MIN))
        else $error("scan did not start on first channel");
    chk_dwell_bound: assert property (scanActive |-> s_q.dwell < dwellLen(s_q.scanExp))
        else $error("dwell overran its length");
    chk_cr_follows_mode: assert property (##1 fieldTerminator == ($past(framedMode) == 2'h0))
        else $error("terminator enable wrong for mode");

endmodule : radio_module_setting_commands

`default_nettype wire

// >>> sim/rmsc_host_model.sv
// Host processor model driving the serial command byte port
`timescale 1ns/1ps
`default_nettype none
module rmsc_host_model (
    input  wire logic       clock,
    output logic            serValid,
    output logic      [7:0] serByte
);
    initial
    begin
        serValid = 1'b0;
        serByte  = 8'h00;
    end

    task automatic send_escape(input logic [7:0] ch, input int pre, input int post);
        repeat (pre) @(posedge clock);
        serValid <= 1'b1;
        serByte  <= ch;
        @(posedge clock);
        serValid <= 1'b0;
        // Idle line does not keep showing the last byte
        serByte  <= ~ch;
        repeat (post) @(posedge clock);
    endtask : send_escape
endmodule : rmsc_host_model
`default_nettype wire

// >>> sim/tb_radio_module_setting_commands.sv
// Self-checking bench for the radio module setting block
`timescale 1ns/1ps
`default_nettype none
module tb_radio_module_setting_commands;
    localparam int GC = 20;
    localparam int SC = 8;
    logic        clock, rst, psel, penable, pwrite, pready, pslverr, serValid, beaconHeard, txRequest;
    logic        cmdMode, fieldTerminator, coordinatorRole, txGrant, txBlock, scanActive, beaconRequest;
    logic        recordAccept, errSeen, cmdExp;
    logic [1:0]  framedMode;
    logic [2:0]  recordCount;
    logic [4:0]  rfChannel, scanChannel, ioOut, ioOe, adcEnable;
    logic [6:0]  energyLevel;
    logic [7:0]  paddr, serByte;
    logic [20:0] baudDivisor;
    logic [31:0] pwdata, prdata, rdat, v, mdl [9];
    logic [7:0]  badA [8] = '{8'h00, 8'h00, 8'h04, 8'h08, 8'h10, 8'h10, 8'h14, 8'h18};
    logic [31:0] badV [8] = '{32'h3, 32'h8, 32'h3d091, 32'h51, 32'ha, 32'h1b, 32'h1, 32'h6};
    int          error_cnt, num_checks, seed, cyc, n, k;

    radio_module_setting_commands #(.GUARD_CYC(GC), .TMO_CYC(10), .SCAN_CYC(SC), .SCAN_CHS(16)) i_dut (
        .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serValid(serValid),
        .serByte(serByte), .beaconHeard(beaconHeard), .txRequest(txRequest), .energyLevel(energyLevel),
        .cmdMode(cmdMode), .framedMode(framedMode), .fieldTerminator(fieldTerminator),
        .coordinatorRole(coordinatorRole), .rfChannel(rfChannel), .baudDivisor(baudDivisor), .txGrant(txGrant),
        .txBlock(txBlock), .scanActive(scanActive), .scanChannel(scanChannel), .beaconRequest(beaconRequest),
        .recordAccept(recordAccept), .recordCount(recordCount), .ioOut(ioOut), .ioOe(ioOe), .adcEnable(adcEnable));
    rmsc_host_model i_host (.clock(clock), .serValid(serValid), .serByte(serByte));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Request held until pready is sampled high; the slave latency is not assumed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the bench cycle ceiling ends a wait that never sees pready
        while (pready !== 1'b1)
            @(posedge clock);
        rdat = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic legal(input logic [7:0] a, input logic [31:0] d);
        logic r;
        r = d < 32'h8000;
        for (int i = 0; i < 5; i++)
            r &= d[3*i+:3] <= 3'h5;
        case (a)
            8'h00: r = d < 32'h8 && d[1:0] <= 2'h2;
            8'h04: r = d <= 32'h3d090;
            8'h08: r = d <= 32'h50;
            8'h0c: r = d <= 32'hff;
            8'h10: r = d >= 32'hb && d <= 32'h1a;
            8'h14: r = d >= 32'h2 && d <= 32'hffff;
            8'h1c: r = d <= 32'h6;
            8'h20: r = 1'b1;
            default: ;
        endcase
        return r;
    endfunction : legal

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        e = !cmdExp || !legal(a, d);
        apb(1'b1, a, d);
        check($sformatf("error %h", a), 32'(errSeen), 32'(e));
        if (!e)
            mdl[a[7:2]] = (a == 8'h04 && d > 32'h7) ? rmsc_pkg::CLK_HZ / ((rmsc_pkg::CLK_HZ + d / 2) / d) : d;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), rdat, ex);
    endtask : rd

    initial
    begin
        seed = 16;
        error_cnt = 0;
        num_checks = 0;
        cyc = 0;
        cmdExp = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        beaconHeard = 1'b0;
        txRequest = 1'b0;
        energyLevel = 7'h0;
        mdl = '{32'h0, 32'h3, 32'h2c, 32'h2b, 32'hc, 32'h64, 32'h0, 32'h0, 32'h0};
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        check("divisor", 32'(baudDivisor), 32'h412);
        for (n = 0; n < 7; n++)
            rd(8'(n << 2), mdl[n]);
        wr(8'h10, 32'h10);
        i_host.send_escape(8'h2a, GC + 2, GC + 3);
        check("cmd wrong char", 32'(cmdMode), 32'h0);
        i_host.send_escape(8'h2b, GC + 2, GC + 3);
        cmdExp = 1'b1;
        check("cmd entry", 32'(cmdMode), 32'h1);
        for (n = 0; n < 8; n++)
        begin
            wr(badA[n], badV[n]);
            rd(badA[n], mdl[badA[n][7:2]]);
        end
        wr(8'h1c, 32'h7);
        rd(8'h20, 32'h3);
        for (n = 0; n < 3; n++)
        begin
            wr(8'h00, 32'((n * 5) & 7));
            repeat (2) @(posedge clock);
            check("framed", 32'(framedMode), 32'(n));
            check("terminator", 32'(fieldTerminator), 32'(n == 0));
            check("role", 32'(coordinatorRole), 32'(n == 1));
        end
        v = 32'hb + $unsigned($random(seed)) % 32'h10;
        wr(8'h10, v);
        repeat (2) @(posedge clock);
        check("channel", 32'(rfChannel), mdl[4]);
        wr(8'h08, 32'h30);
        for (n = 0; n < 3; n++)
        begin
            @(posedge clock);
            txRequest <= 1'b1;
            energyLevel <= 7'(7'h2f + n);
            @(posedge clock);
            txRequest <= 1'b0;
            @(posedge clock);
            check("block", 32'(txBlock), 32'(n == 0));
            check("grant", 32'(txGrant), 32'(n != 0));
        end
        wr(8'h18, 32'h1762);
        repeat (2) @(posedge clock);
        check("io oe", 32'(ioOe), 32'h6);
        check("io out", 32'(ioOut), 32'h4);
        check("io adc", 32'(adcEnable), 32'h1);
        v = 32'h8 + $unsigned($random(seed)) % 32'h3d089;
        wr(8'h04, v);
        rd(8'h04, mdl[1]);
        wr(8'h04, 32'h7);
        check("divisor kept", 32'(baudDivisor), 32'h412);
        for (int e = 0; e < 2; e++)
        begin
            wr(8'h1c, 32'(e));
            n = 0;
            k = 0;
            v = 32'h0;
            fork
                repeat (((SC << e) << 4) + 12)
                begin
                    @(posedge clock);
                    n += int'(beaconRequest === 1'b1);
                    k += int'(scanActive === 1'b1);
                    v += 32'(recordAccept === 1'b1);
                    if (beaconRequest === 1'b1 && n == 1)
                        check("first channel", 32'(scanChannel), 32'hb);
                end
                repeat (6)
                begin
                    repeat (3) @(posedge clock);
                    beaconHeard <= 1'b1;
                    @(posedge clock);
                    beaconHeard <= 1'b0;
                end
            join
            check("requests", n, 32'h10);
            check("dwell cycles", k, 32'((SC << e) << 4));
            check("records", v, 32'h5);
            check("record count", 32'(recordCount), 32'h5);
        end
        wr(8'h20, 32'h1);
        cmdExp = 1'b0;
        repeat (2) @(posedge clock);
        check("cmd left", 32'(cmdMode), 32'h0);
        check("divisor fast", 32'(baudDivisor), 32'h5a);
        i_host.send_escape(8'h2b, GC + 2, GC + 3);
        cmdExp = 1'b1;
        wr(8'h04, 32'h0);
        wr(8'h14, 32'h2);
        repeat (15) @(posedge clock);
        check("cmd held", 32'(cmdMode), 32'h1);
        repeat (10) @(posedge clock);
        check("cmd timed out", 32'(cmdMode), 32'h0);
        check("divisor after timeout", 32'(baudDivisor), 32'h5a);
        finish_test();
    end
endmodule : tb_radio_module_setting_commands
`default_nettype wire
